// ==== shared/sar_adc_consts.svh ====
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define CONV_START_MIN_NS 40
`define CONV_START_CYC ((`CONV_START_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TIME_NS 2200
`define CONV_CYC (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define ACQ_GAP_NS 5000
`define SCLK_HALF_NS 555
`define SCLK_HALF_CYC (`SCLK_HALF_NS / `CLK_PERIOD_NS)
`define SER_BITS 16
`define RESULT_MSB 15
`define BYTE_BITS 8
`define RESULT_RST 16'h0000
`define TWOS_PFS 16'h7FFF
`define TWOS_NFS 16'h8000
`define FIFO_DEPTH 16

`endif

// ==== shared/sar_adc_pkg.sv ====
package sar_adc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_e;

  typedef struct packed {
    logic cs_n;
    logic rd_conv;
    logic byte_sel;
    logic fmt_sb;
    logic ext_clk;
    logic sclk;
    logic tag;
  } pins_s;

  typedef logic [15:0] result_t;

endpackage

// ==== rtl/sar_adc_convert_and_readout.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_consts.svh"

module sar_result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic full;
  wire push = i_in_valid && !full;
  wire pop = i_out_ready && (count != '0);
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      full <= 1'b0;
      o_in_ready <= 1'b1;
    end else begin
      wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      count <= next_count;
      full <= (next_count == (AW+1)'(DEPTH));
      // Ready straight from a flop so the top output is registered
      o_in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule // sar_result_fifo

// Functional notes
// - Both selects low for 40 ns holds the sample and starts conversion N.
// - Convert commands arriving while busy is low are ignored.
// - Tracking restarts at conversion end; host leaves 5 us between commands.
// - Chip select high: no operation and parallel bus released.
// - A conversion start always leaves or puts the parallel bus released.
// - Both low when busy rises restarts conversion with invalid data.
// - Selects combined as level OR; either may fall first.
// - Internal clock mode: previous result shifted out after conversion start.
// - Internal clock mode sends serial data every convert cycle regardless of selects.
// - New result visible once busy rises; earlier reads give previous result, shifted in internal clock mode.
// - Format input high gives straight binary, low gives twos complement.
// - Twos complement 7FFF/0000/8000; straight binary FFFF/8000/0000.
// - First conversion after power-up gives an invalid result.
// - Parallel reads leave register intact; each serial pulse shifts it.
// - Internal mode drives serial clock pin; external mode makes it an input.
// - External clock, select low, read high: shift result on external clock.
// - Parallel bus driven only with read high and select low.
// - Byte select low gives upper byte, high gives lower byte.
// - Parallel output undefined before any valid conversion.
// - Select tied low: internal serial unchanged; read rising affects external outputs.
// - During conversion, enabling the bus shows the previous result, shifted in internal clock mode.
// - Internal mode emits 16 serial clock pulses, top bit first.
module sar_adc_convert_and_readout (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic i_rd_conv,
  input wire logic i_byte_sel,
  input wire logic i_output_format_select,
  input wire logic i_serial_clock_source,
  input wire logic i_serial_bit_clock,
  input wire logic i_tag,
  input wire logic i_core_valid,
  input wire logic [15:0] i_core_result,
  output logic o_core_ready,
  output logic o_busy,
  output logic o_hold,
  output logic o_result_valid,
  output logic [7:0] o_parallel_result_bus,
  output logic o_parallel_result_bus_oe_n,
  output logic o_serial_bit_clock,
  output logic o_serial_bit_clock_oe_n,
  output logic o_serial_result_out
);

  // Offset binary from the core; the top bit flip gives twos complement
  function automatic sar_adc_pkg::result_t fmt_result(input sar_adc_pkg::result_t raw,
                                                      input logic sb);
    fmt_result = sb ? raw : {~raw[`RESULT_MSB], raw[`RESULT_MSB-1:0]};
  endfunction

  sar_adc_pkg::pins_s pins_raw;
  sar_adc_pkg::pins_s sync1;
  sar_adc_pkg::pins_s pins;
  logic sclk_prev;
  sar_adc_pkg::conv_state_e state;
  logic [15:0] low_cnt;
  logic [15:0] conv_timer;
  logic [15:0] half_timer;
  logic [4:0] pulses_left;
  logic sclk_int;
  logic tag_at_start;
  logic sending;
  logic conv_count_one;
  sar_adc_pkg::result_t out_reg;
  sar_adc_pkg::result_t next_out_reg;
  logic fifo_valid;
  sar_adc_pkg::result_t fifo_data;

  assign pins_raw = '{cs_n: i_cs_n, rd_conv: i_rd_conv, byte_sel: i_byte_sel,
                      fmt_sb: i_output_format_select, ext_clk: i_serial_clock_source,
                      sclk: i_serial_bit_clock, tag: i_tag};

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1 <= '{cs_n: 1'b1, rd_conv: 1'b1, default: 1'b0};
      pins <= '{cs_n: 1'b1, rd_conv: 1'b1, default: 1'b0};
      sclk_prev <= 1'b0;
    end else begin
      sync1 <= pins_raw;
      pins <= sync1;
      sclk_prev <= pins.sclk;
    end
  end

  wire idle = (state == sar_adc_pkg::ST_IDLE);
  wire cmd_low = !(pins.cs_n || pins.rd_conv);
  wire start = idle && (low_cnt >= 16'(`CONV_START_CYC));
  wire core_take = (state == sar_adc_pkg::ST_CONV) && (conv_timer == '0) && !sending
                   && fifo_valid;
  wire half_done = (half_timer == '0);
  wire ser_pulse_fall = sending && half_done && sclk_int;
  wire ser_pulse_rise = sending && half_done && !sclk_int && (pulses_left != '0);
  wire ext_fall = pins.ext_clk && !pins.cs_n && pins.rd_conv && sclk_prev && !pins.sclk;
  wire int_start = start && !pins.ext_clk;
  wire [4:0] pulses_after = 5'(pulses_left - 1'b1);
  wire bus_en = !pins.cs_n && pins.rd_conv;
  wire [7:0] bus_byte = pins.byte_sel ? out_reg[`BYTE_BITS-1:0]
                                      : out_reg[`RESULT_MSB -: `BYTE_BITS];

  sar_result_fifo #(
    .WIDTH(16),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_core_valid),
    .i_in_data(i_core_result),
    .o_in_ready(o_core_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(core_take)
  );

  // Load wins over a shift in the same cycle; a late external edge is lost
  always_comb begin
    next_out_reg = out_reg;
    if (core_take) begin
      next_out_reg = fmt_result(fifo_data, pins.fmt_sb);
    end else if (int_start) begin
      next_out_reg = {out_reg[`RESULT_MSB-1:0], 1'b0};
    end else if (ser_pulse_fall && (pulses_after != '0)) begin
      next_out_reg = {out_reg[`RESULT_MSB-1:0], 1'b0};
    end else if (ext_fall) begin
      next_out_reg = {out_reg[`RESULT_MSB-1:0], pins.tag};
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      low_cnt <= '0;
    end else if (!cmd_low || !idle) begin
      low_cnt <= '0;
    end else if (low_cnt < 16'(`CONV_START_CYC)) begin
      low_cnt <= 16'(low_cnt + 1'b1);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= sar_adc_pkg::ST_IDLE;
      conv_timer <= '0;
      o_busy <= 1'b1;
      o_hold <= 1'b0;
    end else begin
      unique case (state)
        sar_adc_pkg::ST_IDLE: begin
          if (start) begin
            state <= sar_adc_pkg::ST_CONV;
            conv_timer <= 16'(`CONV_CYC);
            o_busy <= 1'b0;
            o_hold <= 1'b1;
          end
        end
        sar_adc_pkg::ST_CONV: begin
          conv_timer <= (conv_timer != '0) ? 16'(conv_timer - 1'b1) : conv_timer;
          if (core_take) begin
            state <= sar_adc_pkg::ST_IDLE;
            o_busy <= 1'b1;
            o_hold <= 1'b0;
          end
        end
      endcase
    end
  end

  // Internal serial clock; busy also waits for the 16 pulses to finish
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sending <= 1'b0;
      sclk_int <= 1'b0;
      pulses_left <= '0;
      half_timer <= '0;
      tag_at_start <= 1'b0;
    end else if (int_start) begin
      sending <= 1'b1;
      sclk_int <= 1'b0;
      pulses_left <= 5'(`SER_BITS);
      half_timer <= 16'(`SCLK_HALF_CYC);
      tag_at_start <= pins.tag;
    end else if (sending) begin
      half_timer <= half_done ? 16'(`SCLK_HALF_CYC) : 16'(half_timer - 1'b1);
      if (ser_pulse_rise) begin
        sclk_int <= 1'b1;
      end else if (ser_pulse_fall) begin
        sclk_int <= 1'b0;
        pulses_left <= pulses_after;
        sending <= (pulses_after != '0);
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_reg <= `RESULT_RST;
      o_serial_result_out <= 1'b0;
    end else begin
      out_reg <= next_out_reg;
      if (int_start || (ser_pulse_fall && (pulses_after != '0)) || ext_fall) begin
        o_serial_result_out <= out_reg[`RESULT_MSB];
      end else if (ser_pulse_fall) begin
        o_serial_result_out <= tag_at_start;
      end
    end
  end

  // First completed conversion after reset carries no meaning
  logic [1:0] done_count;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      done_count <= '0;
      o_result_valid <= 1'b0;
    end else if (core_take) begin
      done_count <= (done_count == 2'd2) ? done_count : 2'(done_count + 1'b1);
      o_result_valid <= (done_count != '0);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_parallel_result_bus <= '0;
      o_parallel_result_bus_oe_n <= 1'b1;
      o_serial_bit_clock <= 1'b0;
      o_serial_bit_clock_oe_n <= 1'b1;
    end else begin
      o_parallel_result_bus <= bus_byte;
      o_parallel_result_bus_oe_n <= !bus_en;
      o_serial_bit_clock <= sclk_int;
      o_serial_bit_clock_oe_n <= pins.ext_clk;
    end
  end

endmodule // sar_adc_convert_and_readout
`default_nettype wire

// ==== testbench/sar_adc_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module sar_adc_props (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic i_rd_conv,
  input wire logic i_serial_clock_source,
  input wire logic o_busy,
  input wire logic o_hold,
  input wire logic o_result_valid,
  input wire logic o_parallel_result_bus_oe_n,
  input wire logic o_serial_bit_clock,
  input wire logic o_serial_bit_clock_oe_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Busy-low length, too long for a repetition
  logic [11:0] low_cnt;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst) low_cnt <= 12'h000;
    else low_cnt <= o_busy ? 12'h000 : low_cnt + 12'h001;
  oe_cause_a: assert property (!o_parallel_result_bus_oe_n |->
    $past(!i_cs_n && i_rd_conv, 3) || $past(!i_cs_n && i_rd_conv, 4)) else $error("bus enable");
  cs_high_a: assert property (i_cs_n [*4] |=> o_parallel_result_bus_oe_n)
    else $error("bus not released");
  busy_len_a: assert property ($rose(o_busy) |-> low_cnt >= 12'h0DC)
    else $error("busy too short");
  start_cause_a: assert property ($fell(o_busy) |-> $past(!i_cs_n && !i_rd_conv, 3))
    else $error("start without command");
  hold_busy_a: assert property (o_hold == !o_busy)
    else $error("hold and busy disagree");
  sclk_dir_a: assert property (i_serial_clock_source [*4] |=> o_serial_bit_clock_oe_n)
    else $error("clock pin driven");
  sclk_conv_a: assert property (o_serial_bit_clock |-> !o_busy)
    else $error("clock pulse outside conversion");
  valid_rise_a: assert property ($rose(o_result_valid) |-> $rose(o_busy))
    else $error("valid without load");
  cover property ($fell(o_busy));
  cover property ($fell(o_parallel_result_bus_oe_n));
  cover property ($rose(o_serial_bit_clock));
endmodule // sar_adc_props
bind sar_adc_convert_and_readout sar_adc_props i_sar_adc_props (.i_clk_sys, .i_sys_rst,
  .i_cs_n, .i_rd_conv, .i_serial_clock_source, .o_busy, .o_hold, .o_result_valid,
  .o_parallel_result_bus_oe_n, .o_serial_bit_clock, .o_serial_bit_clock_oe_n);
`default_nettype wire

// ==== testbench/core_result_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module core_result_model (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ready,
  output logic o_valid,
  output sar_adc_pkg::result_t o_result
);
  sar_adc_pkg::result_t words [6] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h0000, 16'h1234,
    16'hABCD};
  logic [4:0] idx;
  // Twenty words so the buffer fills and refuses
  assign o_valid = idx < 5'h14;
  assign o_result = idx < 5'h06 ? words[idx[2:0]] : {3'h0, idx, 3'h0, idx};
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst) idx <= 5'h00;
    else if (o_valid && i_ready) idx <= idx + 5'h01;
endmodule // core_result_model
`default_nettype wire

// ==== testbench/sar_adc_convert_and_readout_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module sar_adc_convert_and_readout_tb;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic cs_n = 1'b1, rd = 1'b1, bsel = 1'b0, fmt = 1'b1, src = 1'b1, xclk = 1'b0;
  logic cv, cr, busy, hold, rv, boe_n, sclk, soe_n, sdo, sclk_d = 1'b0;
  logic [7:0] bus;
  sar_adc_pkg::result_t craw, cap, xcap;
  int failures = 0, tests_run = 0, cyc = 0, npulse = 0;
  // Shared clock pin: device drives it only when its enable is low
  wire clk_pin = !soe_n ? sclk : xclk;
  always #5 i_clk_sys = ~i_clk_sys;
  core_result_model i_core_result_model (.i_clk_sys, .i_sys_rst, .i_ready(cr), .o_valid(cv),
    .o_result(craw));
  sar_adc_convert_and_readout i_sar_adc_convert_and_readout (.i_clk_sys, .i_sys_rst,
    .i_cs_n(cs_n), .i_rd_conv(rd), .i_byte_sel(bsel), .i_output_format_select(fmt),
    .i_serial_clock_source(src), .i_serial_bit_clock(clk_pin), .i_tag(1'b0),
    .i_core_valid(cv), .i_core_result(craw), .o_core_ready(cr), .o_busy(busy), .o_hold(hold),
    .o_result_valid(rv), .o_parallel_result_bus(bus), .o_parallel_result_bus_oe_n(boe_n),
    .o_serial_bit_clock(sclk), .o_serial_bit_clock_oe_n(soe_n), .o_serial_result_out(sdo));
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    sclk_d <= sclk;
    if (sclk && !sclk_d) begin
      cap <= {cap[14:0], sdo};
      npulse <= npulse + 1;
    end
    if (cyc == 30000) begin
      failures++;
      test_done();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task wait_busy(input logic lvl);
    for (int k = 0; k < 3000 && busy !== lvl; k++) tick(1);
  endtask
  task conv(input logic f, input logic s);
    tick(500);
    fmt <= f;
    src <= s;
    cs_n <= 1'b0;
    rd <= 1'b0;
    wait_busy(1'b0);
    rd <= 1'b1;
  endtask
  task rd_byte(input logic b, input logic [7:0] e);
    tick(1);
    cs_n <= 1'b0;
    rd <= 1'b1;
    bsel <= b;
    tick(4);
    chk(16'(boe_n), 16'h0000);
    chk(16'(bus), 16'(e));
  endtask
  task rd16(input logic [15:0] e);
    rd_byte(1'b0, e[15:8]);
    rd_byte(1'b1, e[7:0]);
  endtask
  initial begin
    tick(8);
    i_sys_rst <= 1'b0;
    chk(16'(busy), 16'h0001);
    chk(16'(boe_n), 16'h0001);
    tick(40);
    chk(16'(cr), 16'h0000);
    conv(1'b1, 1'b1);
    wait_busy(1'b1);
    chk(16'(rv), 16'h0000);
    conv(1'b1, 1'b1);
    wait_busy(1'b1);
    chk(16'(rv), 16'h0001);
    rd16(16'hFFFF);
    conv(1'b0, 1'b1);
    wait_busy(1'b1);
    rd16(16'h0000);
    conv(1'b0, 1'b1);
    rd16(16'h0000);
    wait_busy(1'b1);
    rd16(16'h8000);
    $display("test parallel done");
    conv(1'b1, 1'b1);
    tick(20);
    rd <= 1'b0;
    tick(6);
    rd <= 1'b1;
    wait_busy(1'b1);
    tick(30);
    chk(16'(busy), 16'h0001);
    rd16(16'h1234);
    cs_n <= 1'b1;
    tick(5);
    chk(16'(boe_n), 16'h0001);
    $display("test ignore done");
    conv(1'b1, 1'b0);
    tick(2);
    chk(16'(soe_n), 16'h0000);
    wait_busy(1'b1);
    chk(16'(npulse), 16'h0010);
    chk(cap, 16'h1234);
    src <= 1'b1;
    rd16(16'hABCD);
    for (int i = 0; i < 17; i++) begin
      xclk <= 1'b1;
      tick(4);
      xcap = {xcap[14:0], sdo};
      xclk <= 1'b0;
      tick(4);
    end
    chk(xcap, 16'hABCD);
    $display("test serial done");
    for (int i = 6; i < 20; i++) begin
      conv(1'b1, 1'b1);
      wait_busy(1'b1);
      rd16({3'h0, 5'(i), 3'h0, 5'(i)});
    end
    chk(16'(cr), 16'h0001);
    conv(1'b1, 1'b1);
    tick(400);
    chk(16'(busy), 16'h0000);
    $display("test drain done");
    test_done();
  end
endmodule // sar_adc_convert_and_readout_tb
`default_nettype wire
